/* File: pkg/pdbt_regs.vh */
`ifndef PDBT_REGS_VH
`define PDBT_REGS_VH

// Clock rate and times
`define PDBT_CLK_MHZ        25
`define PDBT_FILT_US        130
`define PDBT_INIT_US        5
// One compare interval: 71.5 s / 16, in microseconds
`define PDBT_TICK_US        4468750
`define PDBT_TICK_SHIFT     4

// Register byte offsets
`define PDBT_OFF_CTRL       8'h00
`define PDBT_OFF_PDT        8'h04
`define PDBT_OFF_CBAL       8'h08
`define PDBT_OFF_BTMR0      8'h0c
`define PDBT_OFF_BTMR5      8'h20
`define PDBT_OFF_STAT       8'h24

// Field positions
`define PDBT_CTRL_SWPD      8
`define PDBT_STEP_LSB       3
`define PDBT_STEP_MSB       7
`define PDBT_CB_LSB         2
`define PDBT_CB_MSB         7
`define PDBT_STAT_FULLPD    0
`define PDBT_STAT_SOFTPD    1
`define PDBT_STAT_PIN       2
`define PDBT_STAT_PDTRUN    3
`define PDBT_STAT_BALRUN    4

// Reset values
`define PDBT_RST_STEP       5'h00
`define PDBT_RST_CB         6'h00

`endif

/* File: hdl/pdbt_top.v */
// Behaviour
// - Pin must stay low 130 us to power down, high 130 us to leave.
// - After reset the first filter run is 5 us; 5 us high gives power-on.
// - Qualified pin fall powers the whole device down.
// - Control bit D8 set gives software power-down.
// - Delay timer 0 to 31 steps of 71.5 s before power-down.
// - Pin fall or D8 set starts delay; expiry samples the pin.
// - Delay timer register resets to zero.
// - Delay write while running restarts count; zero expires at once.
// - Pin rise does not cancel a running delay.
// - Six balance outputs follow cell balance register, reset zero.
// - Delay zero: outputs off at once; else on until delay expiry. Here only full power-down clears them; software power-down leaves them on.
// - Six balance timers of 5-bit steps; zero means no timer.
// - Shared counter starts on nonzero balance write with a timer set.
// - Every 4.5 s compare count with timers; reached output goes off.
// - Expired output and its register bit clear; timers kept.
// - Balance register write overrides timers immediately.
// - Timer write to an on output restarts counter; zero switches off. Here only a running counter restarts; an idle counter stays idle.
// - First balance output at bit D2, others upward.
// - Timer step LSB sits at bit D3.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "pdbt_regs.vh"

module pdbt_top #(
    parameter P_FILT_CYC = `PDBT_FILT_US * `PDBT_CLK_MHZ,
    parameter P_INIT_CYC = `PDBT_INIT_US * `PDBT_CLK_MHZ,
    parameter P_TICK_CYC = `PDBT_TICK_US * `PDBT_CLK_MHZ
) (
    input  wire        i_clk,
    input  wire        i_rst_b,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    input  wire        i_power_down_n_pin,
    output wire        o_full_pd,
    output wire        o_soft_pd,
    output wire [5:0]  o_balance_gate_output
);

    function is_tmr;
        input [7:0] a;
        begin
            is_tmr = (a >= `PDBT_OFF_BTMR0) && (a <= `PDBT_OFF_BTMR5) &&
                     (a[1:0] == 2'b00);
        end
    endfunction

    function [2:0] tmr_idx;
        input [7:0] a;
        reg   [7:0] d;
        begin
            d       = a - `PDBT_OFF_BTMR0;
            tmr_idx = d[4:2];
        end
    endfunction

    function [8:0] step_ticks;
        input [4:0] s;
        begin
            step_ticks = {s, 4'h0};
        end
    endfunction

    reg  [31:0] prdata_q;
    reg         pready_q;
    reg         pslverr_q;
    reg  [2:0]  pin_sync_q;
    reg  [11:0] filt_cnt_q;
    reg         pin_filt_q;
    reg         pin_prev_q;
    reg         init_q;
    reg         full_pd_q;
    reg         soft_pd_q;
    reg         ctrl_swpd_q;
    reg  [4:0]  pdt_q;
    reg         pdt_run_q;
    reg         pdt_sw_q;
    reg  [31:0] pdt_pre_q;
    reg  [8:0]  pdt_ticks_q;
    reg  [5:0]  cb_q;
    reg  [5:0]  cb_d;
    reg  [4:0]  tmr_q [0:5];
    reg         bal_run_q;
    reg         bal_run_d;
    reg  [31:0] bal_pre_q;
    reg  [31:0] bal_pre_d;
    reg  [8:0]  bal_ticks_q;
    reg  [8:0]  bal_ticks_d;
    wire [5:0]  expire;
    wire [5:0]  tmr_set;

    wire acc    = i_psel && i_penable && pready_q;
    wire wr     = acc && i_pwrite;
    wire [4:0] wstep = i_pwdata[`PDBT_STEP_MSB:`PDBT_STEP_LSB];
    wire [5:0] wcb   = i_pwdata[`PDBT_CB_MSB:`PDBT_CB_LSB];

    // APB: one wait state, so every access completes on the second
    // access-phase edge.
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            pready_q  <= i_psel && i_penable && !pready_q;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
            if (i_psel && i_penable && !pready_q)
            begin
                if (is_tmr(i_paddr))
                    prdata_q <= {24'h0, tmr_q[tmr_idx(i_paddr)], 3'h0};
                else
                begin
                    case (i_paddr)
                        `PDBT_OFF_CTRL: prdata_q <= {23'h0, ctrl_swpd_q, 8'h0};
                        `PDBT_OFF_PDT:  prdata_q <= {24'h0, pdt_q, 3'h0};
                        `PDBT_OFF_CBAL: prdata_q <= {24'h0, cb_q, 2'h0};
                        `PDBT_OFF_STAT:
                            prdata_q <= {27'h0, bal_run_q, pdt_run_q,
                                         pin_filt_q, soft_pd_q, full_pd_q};
                        default:        pslverr_q <= 1'b1;
                    endcase
                end
                // Writes answer with zero data, reads only carry values
                if (i_pwrite)
                    prdata_q <= 32'h0;
            end
        end
    end

    // Pin synchroniser; first stage feeds only the second
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
            pin_sync_q <= 3'h0;
        else
            pin_sync_q <= {pin_sync_q[1:0], i_power_down_n_pin};
    end

    wire pin_new = (pin_sync_q[1] == pin_sync_q[2]) &&
                   (pin_sync_q[2] != pin_filt_q);
    wire [11:0] filt_lim = init_q ? P_INIT_CYC[11:0] - 12'h1
                                  : P_FILT_CYC[11:0] - 12'h1;

    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            filt_cnt_q <= 12'h0;
            pin_filt_q <= 1'b0;
            pin_prev_q <= 1'b0;
            init_q     <= 1'b1;
        end
        else
        begin
            pin_prev_q <= pin_filt_q;
            if (!pin_new)
                filt_cnt_q <= 12'h0;
            else if (filt_cnt_q == filt_lim)
            begin
                filt_cnt_q <= 12'h0;
                pin_filt_q <= ~pin_filt_q;
                init_q     <= 1'b0;
            end
            else
                filt_cnt_q <= filt_cnt_q + 12'h1;
        end
    end

    wire pin_fall = pin_prev_q && !pin_filt_q;
    wire sw_set   = wr && (i_paddr == `PDBT_OFF_CTRL) &&
                    i_pwdata[`PDBT_CTRL_SWPD] && !ctrl_swpd_q;
    wire trig     = pin_fall || sw_set;
    wire pdt_wr   = wr && (i_paddr == `PDBT_OFF_PDT);
    wire pdt_tick = pdt_run_q && (pdt_pre_q == P_TICK_CYC - 1);
    wire [8:0] pdt_ticks_n = pdt_ticks_q + 9'h1;
    // Source of an expiry: software only when the pin fall is absent
    wire exp_sw   = trig ? !pin_fall : pdt_sw_q;
    wire pdt_exp  = (trig && pdt_q == 5'h0) ||
                    (pdt_wr && pdt_run_q && wstep == 5'h0) ||
                    (pdt_tick && pdt_ticks_n >= step_ticks(pdt_q));
    // Entry clears outputs on the same edge as full_pd rises, so gates
    // are never seen on while the device is already powered down.
    wire pd_enter = !full_pd_q && pdt_exp && !pin_filt_q;
    wire rst_all  = !i_rst_b || full_pd_q || pd_enter;

    // full power-down entry on expiry with pin low
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
            full_pd_q <= 1'b1;
        else if (full_pd_q)
            full_pd_q <= !pin_filt_q;
        else if (pdt_exp && !pin_filt_q)
            full_pd_q <= 1'b1;
    end

    // Full power-down holds all control state at its power-on value,
    // so leaving it behaves as a fresh power-on reset.
    always @(posedge i_clk)
    begin
        if (rst_all)
        begin
            ctrl_swpd_q <= 1'b0;
            soft_pd_q   <= 1'b0;
            pdt_q       <= `PDBT_RST_STEP;
            pdt_run_q   <= 1'b0;
            pdt_sw_q    <= 1'b0;
            pdt_pre_q   <= 32'h0;
            pdt_ticks_q <= 9'h0;
        end
        else
        begin
            if (wr && i_paddr == `PDBT_OFF_CTRL)
            begin
                ctrl_swpd_q <= i_pwdata[`PDBT_CTRL_SWPD];
                if (!i_pwdata[`PDBT_CTRL_SWPD])
                    soft_pd_q <= 1'b0;
            end
            if (pdt_wr)
                pdt_q <= wstep;
            if (pdt_run_q)
            begin
                pdt_pre_q <= pdt_tick ? 32'h0 : pdt_pre_q + 32'h1;
                if (pdt_tick)
                    pdt_ticks_q <= pdt_ticks_n;
            end
            if (pdt_exp)
            begin
                pdt_run_q <= 1'b0;
                if (pin_filt_q && exp_sw)
                    soft_pd_q <= 1'b1;
            end
            else if (trig)
            begin
                pdt_run_q   <= 1'b1;
                pdt_sw_q    <= !pin_fall;
                pdt_pre_q   <= 32'h0;
                pdt_ticks_q <= 9'h0;
            end
            else if (pdt_wr && pdt_run_q)
            begin
                pdt_pre_q   <= 32'h0;
                pdt_ticks_q <= 9'h0;
            end
            // pin rise is ignored while running
        end
    end

    wire bal_tick = bal_run_q && (bal_pre_q == P_TICK_CYC - 1);
    wire [8:0] bal_ticks_n = bal_ticks_q + 9'h1;

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : g_cmp
            assign tmr_set[g] = (tmr_q[g] != 5'h0);
            assign expire[g]  = bal_tick && cb_q[g] && tmr_set[g] &&
                                (bal_ticks_n >= step_ticks(tmr_q[g]));
        end
    endgenerate

    always @*
    begin
        bal_pre_d   = bal_tick ? 32'h0 : bal_pre_q + 32'h1;
        bal_ticks_d = bal_tick ? bal_ticks_n : bal_ticks_q;
        bal_run_d   = bal_run_q;
        cb_d        = cb_q & ~expire;
        if (wr && i_paddr == `PDBT_OFF_CBAL)
        begin
            cb_d = wcb;
            if (!bal_run_q && wcb != 6'h0 && tmr_set != 6'h0)
            begin
                bal_run_d   = 1'b1;
                bal_pre_d   = 32'h0;
                bal_ticks_d = 9'h0;
            end
        end
        // write to an on output's timer
        if (wr && is_tmr(i_paddr) && cb_q[tmr_idx(i_paddr)])
        begin
            bal_pre_d   = 32'h0;
            bal_ticks_d = 9'h0;
            if (wstep == 5'h0)
                cb_d[tmr_idx(i_paddr)] = 1'b0;
        end
        // Counter idles once no timed output is left on
        if ((cb_d & tmr_set) == 6'h0)
            bal_run_d = 1'b0;
        if (!bal_run_d)
        begin
            bal_pre_d   = 32'h0;
            bal_ticks_d = 9'h0;
        end
    end

    always @(posedge i_clk)
    begin : p_bal
        integer k;
        if (rst_all)
        begin
            cb_q        <= `PDBT_RST_CB;
            bal_run_q   <= 1'b0;
            bal_pre_q   <= 32'h0;
            bal_ticks_q <= 9'h0;
            for (k = 0; k < 6; k = k + 1)
                tmr_q[k] <= `PDBT_RST_STEP;
        end
        else
        begin
            cb_q        <= cb_d;
            bal_run_q   <= bal_run_d;
            bal_pre_q   <= bal_pre_d;
            bal_ticks_q <= bal_ticks_d;
            if (wr && is_tmr(i_paddr))
                tmr_q[tmr_idx(i_paddr)] <= wstep;
        end
    end

    assign o_prdata              = prdata_q;
    assign o_pready              = pready_q;
    assign o_pslverr             = pslverr_q;
    assign o_full_pd             = full_pd_q;
    assign o_soft_pd             = soft_pd_q;
    assign o_balance_gate_output = cb_q;

endmodule // pdbt_top

/* File: tb/pdbt_props.sv */
`timescale 1ns/1ns
module pdbt_props #(
    parameter P_FILT_CYC = 3250,
    parameter P_INIT_CYC = 125
) (
    input wire        i_clk,
    input wire        i_rst_b,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [7:0]  i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire        i_power_down_n_pin,
    input wire        o_full_pd,
    input wire        o_soft_pd,
    input wire [5:0]  o_balance_gate_output
);
    // Raw high run of the pin; the filter can never beat it
    reg  [11:0] hi_q;
    wire        wr_ok = i_psel && i_penable && i_pwrite && o_pready;
    always @(posedge i_clk)
    begin
        if (!i_rst_b || !i_power_down_n_pin)
            hi_q <= 12'h000;
        else if (hi_q != 12'hfff)
            hi_q <= hi_q + 12'h001;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    property p_exit;
        $fell(o_full_pd) |-> hi_q >= P_INIT_CYC;
    endproperty
    a_exit: assert property (p_exit)
        else $error("power-down left without steady high pin");
    property p_off;
        o_full_pd |-> o_balance_gate_output == 6'h00 && !o_soft_pd;
    endproperty
    a_off: assert property (p_off)
        else $error("outputs active in full power-down");
    property p_gate;
        |(o_balance_gate_output & ~$past(o_balance_gate_output))
            |-> $past(wr_ok) || $past(wr_ok, 2);
    endproperty
    a_gate: assert property (p_gate)
        else $error("balance output rose without a write");
    property p_soft;
        $fell(o_soft_pd) |-> $past(wr_ok) || $past(wr_ok, 2) || o_full_pd;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft power-down left without a write");
    property p_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("pready longer than one cycle");
    property p_wait;
        $rose(i_penable) && i_psel |-> ##[1:2] o_pready;
    endproperty
    a_wait: assert property (p_wait)
        else $error("access not answered in time");
    property p_err;
        o_pslverr |-> o_pready;
    endproperty
    a_err: assert property (p_err)
        else $error("pslverr without pready");
    property p_rdz;
        !o_pready |-> o_prdata == 32'h0;
    endproperty
    a_rdz: assert property (p_rdz)
        else $error("read data outside a completion");
    c_exit: cover property ($fell(o_full_pd));
    c_soft: cover property ($rose(o_soft_pd));
    c_gate: cover property ($fell(|o_balance_gate_output));
endmodule // pdbt_props

bind pdbt_top pdbt_props #(
    .P_FILT_CYC(P_FILT_CYC),
    .P_INIT_CYC(P_INIT_CYC)
) i_pdbt_props (
    .i_clk                 (i_clk),
    .i_rst_b               (i_rst_b),
    .i_psel                (i_psel),
    .i_penable             (i_penable),
    .i_pwrite              (i_pwrite),
    .i_paddr               (i_paddr),
    .i_pwdata              (i_pwdata),
    .o_prdata              (o_prdata),
    .o_pready              (o_pready),
    .o_pslverr             (o_pslverr),
    .i_power_down_n_pin    (i_power_down_n_pin),
    .o_full_pd             (o_full_pd),
    .o_soft_pd             (o_soft_pd),
    .o_balance_gate_output (o_balance_gate_output)
);

/* File: tb/pdbt_host.sv */
`timescale 1ns/1ns
module pdbt_host (
    input  wire         i_clk,
    input  wire         i_pready,
    output logic        o_psel,
    output logic        o_penable,
    output logic        o_pwrite,
    output logic [7:0]  o_paddr,
    output logic [31:0] o_pwdata,
    output logic        o_pin
);
    // conversion start not modelled; host never converts
    initial
    begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
        o_pin = 1'b1;
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        // Only the bench watchdog ends a hang here
        do
        begin
            @(posedge i_clk);
        end while (i_pready !== 1'b1);
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // Released lines must not keep looking valid
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
    task set_pin(input logic v);
        @(posedge i_clk);
        o_pin <= v;
    endtask
endmodule // pdbt_host

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`include "pdbt_regs.vh"
module testbench;
    logic        i_clk;
    logic        i_rst_b;
    wire         psel, pen, pwr, pin, rdy, err, fpd, spd;
    wire  [7:0]  addr;
    wire  [31:0] wdat, rdat;
    wire  [5:0]  gates;
    int          failures, cmp_count;
    logic [32:0] notes[$];
    logic [7:0]  lfsr_q;
    localparam logic [7:0] T0 = `PDBT_OFF_BTMR0;
    localparam logic [7:0] T1 = `PDBT_OFF_BTMR0 + 8'h04;
    localparam logic [7:0] CB = `PDBT_OFF_CBAL;
    localparam logic [7:0] PT = `PDBT_OFF_PDT;
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    pdbt_top #(.P_FILT_CYC(20), .P_INIT_CYC(5), .P_TICK_CYC(4)) i_pdbt_top (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat),
        .o_pready(rdy), .o_pslverr(err), .i_power_down_n_pin(pin),
        .o_full_pd(fpd), .o_soft_pd(spd), .o_balance_gate_output(gates));
    pdbt_host i_pdbt_host (
        .i_clk(i_clk), .i_pready(rdy), .o_psel(psel), .o_penable(pen),
        .o_pwrite(pwr), .o_paddr(addr), .o_pwdata(wdat), .o_pin(pin));
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        notes.push_back(33'h0);
        i_pdbt_host.xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        notes.push_back(e);
        // Random write data on reads; the slave must ignore it
        lfsr_q = lfsr_next(lfsr_q);
        i_pdbt_host.xfer(1'b0, a, {24'h0, lfsr_q});
    endtask
    // State is {gates, full power-down, soft power-down}
    task st(input logic [7:0] e);
        repeat (2) @(negedge i_clk);
        chk({25'h0, gates, fpd, spd}, {25'h0, e});
    endtask
    task wait_pd(input logic v);
        int n;
        n = 0;
        while (fpd !== v && n < 400)
        begin
            @(posedge i_clk);
            n++;
        end
    endtask
    task give_verdict;
        // An access that never completed leaves its note behind
        if (notes.size() != 0)
            failures++;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        if (rdy === 1'b1)
        begin
            if (notes.size() == 0)
                failures++;
            else
                chk({err, rdat}, notes.pop_front());
        end
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        failures++;
        give_verdict;
    end
    initial
    begin
        failures = 0;
        cmp_count = 0;
        lfsr_q = 8'h3b;
        i_rst_b = 1'b0;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        wait_pd(1'b0);
        st(8'h00);
        repeat (10) @(posedge i_clk);
        rd(PT, 33'h0);
        rd(CB, 33'h0);
        rd(`PDBT_OFF_BTMR5, 33'h0);
        rd(8'h30, {1'b1, 32'h0});
        $display("test reset done");
        wr(T0, 32'h10);
        wr(T1, 32'h18);
        wr(CB, 32'h0c);
        st(8'h0c);
        repeat (140) @(posedge i_clk);
        st(8'h08);
        repeat (80) @(posedge i_clk);
        st(8'h00);
        rd(CB, 33'h0);
        rd(T0, 33'h10);
        wr(CB, 32'h0c);
        wr(CB, 32'h08);
        st(8'h08);
        repeat (150) @(posedge i_clk);
        wr(T1, 32'h18);
        repeat (100) @(posedge i_clk);
        st(8'h08);
        wr(T1, 32'h0);
        st(8'h00);
        $display("test balance done");
        wr(T0, 32'h0);
        wr(CB, 32'h04);
        wr(PT, 32'h08);
        i_pdbt_host.set_pin(1'b0);
        repeat (40) @(posedge i_clk);
        wr(PT, 32'h10);
        repeat (80) @(posedge i_clk);
        st(8'h04);
        wait_pd(1'b1);
        st(8'h02);
        repeat (60) @(posedge i_clk);
        i_pdbt_host.set_pin(1'b1);
        wait_pd(1'b0);
        st(8'h00);
        $display("test delay done");
        wr(`PDBT_OFF_CTRL, 32'h100);
        st(8'h01);
        wr(`PDBT_OFF_CTRL, 32'h0);
        st(8'h00);
        wr(CB, 32'h04);
        lfsr_q = lfsr_next(lfsr_q);
        i_pdbt_host.set_pin(1'b0);
        repeat (lfsr_q[3:0]) @(posedge i_clk);
        i_pdbt_host.set_pin(1'b1);
        repeat (30) @(posedge i_clk);
        st(8'h04);
        i_pdbt_host.set_pin(1'b0);
        repeat (30) @(posedge i_clk);
        st(8'h02);
        $display("test soft and glitch done");
        give_verdict;
    end
endmodule // testbench
